// ### fsprw_ctrl.sv
// Purpose: Decide where program stores may start, sequence page operations, stall the core
//          and keep the concurrent-read region blocked and flagged.
// Assumes: Core requests arrive synchronous to sys_clk_i; lock bits reset to unprogrammed
//          since nonvolatile storage is outside this block.
// Notes:   One page operation at a time; new requests are refused while one runs.
`timescale 1ns/100ps
`default_nettype none
module fsprw_ctrl #(
   parameter int unsigned ERASE_CYC = fsprw_pkg::PAGE_ERASE_CYC,
   parameter int unsigned WRITE_CYC = fsprw_pkg::PAGE_WRITE_CYC
) (
   // Clock and reset
   input  wire logic                         sys_clk_i,
   input  wire logic                         rst_b_i,
   // Configuration
   input  wire logic [1:0]                   boot_size_fuses_i,
   // Store program memory request from the core
   input  wire logic                         store_program_memory_instr_i,
   input  wire fsprw_pkg::fsprw_op_t         spm_op_i,
   input  wire logic [fsprw_pkg::ADDR_W-1:0] pc_addr_i,
   input  wire logic [fsprw_pkg::ADDR_W-1:0] spm_addr_i,
   // Fetch and program memory load from the core
   input  wire logic                         fetch_req_i,
   input  wire logic                         program_memory_load_i,
   input  wire logic [fsprw_pkg::ADDR_W-1:0] read_addr_i,
   // Lock bits
   input  wire logic                         lock_set_i,
   input  wire logic [1:0]                   application_lock_bits_set_i,
   input  wire logic [1:0]                   boot_section_lock_bits_set_i,
   input  wire logic                         chip_erase_i,
   // Busy flag clear from software
   input  wire logic                         busy_flag_clear_i,
   // Flash macro control
   output logic                              flash_erase_o,
   output logic                              flash_write_o,
   output logic [fsprw_pkg::PAGE_W-1:0]      flash_page_o,
   // Core status
   output logic                              cpu_stall_o,
   output logic                              read_valid_o,
   output logic                              spm_accepted_o,
   output logic                              spm_rejected_o,
   output logic                              concurrent_region_busy_flag_o,
   output logic [1:0]                        application_lock_bits_o,
   output logic [1:0]                        boot_section_lock_bits_o
);
   import fsprw_pkg::*;

   typedef enum logic [1:0] {FSPRW_IDLE, FSPRW_ERASE, FSPRW_WRITE} fsprw_state_t;

   fsprw_state_t      state_q,  state_d;
   logic [TIMER_W-1:0] timer_q, timer_d;
   logic [PAGE_W-1:0]  page_q,  page_d;
   logic               stall_q, stall_d;
   logic               busy_q,  busy_d;
   logic               acc_q,   acc_d;
   logic               rej_q,   rej_d;

   logic [ADDR_W-1:0]  boot_start;
   logic               pc_in_boot;
   logic               tgt_in_boot;
   logic               tgt_in_conc;
   logic               app_wr_block, app_rd_block;
   logic               boot_wr_block, boot_rd_block;
   logic               locked;
   logic               start;
   logic               rd_in_conc;
   logic               rd_in_boot;
   logic               rd_locked;

   // Boot section boundary from the fuses; every choice lies at or above the
   // stalling region start, so the boot loader never sits in the concurrent region.
   always_comb begin
      unique case (boot_size_fuses_i)
         2'h0: boot_start = BOOT_START_0;                       // [R3] [R10]
         2'h1: boot_start = BOOT_START_1;                       // [R3] [R10]
         2'h2: boot_start = BOOT_START_2;                       // [R3] [R10]
         2'h3: boot_start = BOOT_START_3;                       // [R3] [R10]
      endcase
   end

   assign pc_in_boot  = (pc_addr_i >= boot_start);              // [R3]
   assign tgt_in_boot = (spm_addr_i >= boot_start);             // [R3]
   assign tgt_in_conc = (spm_addr_i < STALL_REGION_START);      // [R4]

   fsprw_lock_cell u_app_lock (
      .sys_clk_i   (sys_clk_i),
      .rst_b_i     (rst_b_i),
      .set_i       (lock_set_i),
      .set_val_i   (application_lock_bits_set_i),
      .chip_erase_i(chip_erase_i),
      .lock_o      (application_lock_bits_o),                   // [R14]
      .wr_block_o  (app_wr_block),
      .rd_block_o  (app_rd_block)
   );

   fsprw_lock_cell u_boot_lock (
      .sys_clk_i   (sys_clk_i),
      .rst_b_i     (rst_b_i),
      .set_i       (lock_set_i),
      .set_val_i   (boot_section_lock_bits_set_i),
      .chip_erase_i(chip_erase_i),
      .lock_o      (boot_section_lock_bits_o),                  // [R15]
      .wr_block_o  (boot_wr_block),
      .rd_block_o  (boot_rd_block)
   );

   // Each section is guarded only by its own lock set.
   assign locked = tgt_in_boot ? boot_wr_block : app_wr_block;  // [R14] [R15] [R18]

   // Any page of the whole flash may be targeted once the core runs boot code.
   assign start = store_program_memory_instr_i && (state_q == FSPRW_IDLE)
                  && pc_in_boot && !locked                      // [R1] [R2]
                  && (spm_op_i != FSPRW_OP_NONE);

   // Reads: loads across sections obey the read-lock of the target section.
   assign rd_in_conc = (read_addr_i < STALL_REGION_START);
   assign rd_in_boot = (read_addr_i >= boot_start);
   assign rd_locked  = program_memory_load_i &&
                       ((rd_in_boot && !pc_in_boot && boot_rd_block) ||
                        (!rd_in_boot && pc_in_boot && app_rd_block)); // [R18]

   // The concurrent region returns nothing valid while it is blocked; the stalling
   // region keeps serving fetches and loads unless the core itself is stalled or a read lock blocks the load.
   assign read_valid_o = (fetch_req_i || program_memory_load_i) && !stall_q
                         && !(rd_in_conc && busy_q) && !rd_locked; // [R5] [R7]

   always_comb begin
      state_d = state_q;
      timer_d = timer_q;
      page_d  = page_q;
      stall_d = stall_q;
      busy_d  = busy_q;
      acc_d   = 1'b0;
      rej_d   = 1'b0;
      unique case (state_q)
         FSPRW_IDLE: begin
            if (start) begin
               acc_d   = 1'b1;
               // Page organisation only matters here: the offset bits are dropped.
               page_d  = spm_addr_i[ADDR_W-1:PAGE_OFS_W];       // [R13]
               state_d = (spm_op_i == FSPRW_OP_ERASE) ? FSPRW_ERASE : FSPRW_WRITE;
               timer_d = (spm_op_i == FSPRW_OP_ERASE) ?
                         TIMER_W'(ERASE_CYC - 1) : TIMER_W'(WRITE_CYC - 1);
               stall_d = !tgt_in_conc;                          // [R6] [R16]
               if (tgt_in_conc) begin
                  busy_d = 1'b1;                                // [R19]
               end
            end
         end
         FSPRW_ERASE,
         FSPRW_WRITE: begin
            if (timer_q == '0) begin
               state_d = FSPRW_IDLE;
               stall_d = 1'b0;                                  // [R16]
            end else begin
               timer_d = timer_q - 1'b1;
            end
         end
      endcase
      // Any request that does not start is refused, including one that arrives
      // while a page operation runs, so the core always gets an answer.
      if (store_program_memory_instr_i && !start) begin
         rej_d = 1'b1;                                          // [R1] [R13]
      end
      // Software may only clear the flag once the operation is over; a new start
      // in the same cycle wins over the clear.
      if (busy_flag_clear_i && (state_q == FSPRW_IDLE) && !start) begin
         busy_d = 1'b0;                                         // [R11] [R19]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state_q <= FSPRW_IDLE;
         timer_q <= '0;
         page_q  <= '0;
         stall_q <= 1'b0;
         busy_q  <= 1'b0;
         acc_q   <= 1'b0;
         rej_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
         page_q  <= page_d;
         stall_q <= stall_d;
         busy_q  <= busy_d;
         acc_q   <= acc_d;
         rej_q   <= rej_d;
      end
   end

   assign flash_erase_o                 = (state_q == FSPRW_ERASE);
   assign flash_write_o                 = (state_q == FSPRW_WRITE);
   assign flash_page_o                  = page_q;
   assign cpu_stall_o                   = stall_q;              // [R6] [R16]
   assign concurrent_region_busy_flag_o = busy_q;               // [R11]
   assign spm_accepted_o                = acc_q;
   assign spm_rejected_o                = rej_q;
endmodule : fsprw_ctrl
`default_nettype wire

// ### fsprw_pkg.sv
// Purpose: Constants and types for the flash self-programming and concurrent-read control.
// Assumes: Word addressed program flash of 64K bytes, 32K words, 128-word pages.
// Notes:   Region and section limits are word addresses.
// Overview of operation
// R1 - Ignore program store from application section
// R2 - Boot code may program every page
// R3 - Boot size setting sets section boundary
// R4 - Fixed concurrent and stalling region split
// R5 - Serve stalling region fetches during concurrent programming
// R6 - Stall core when stalling page programmed
// R7 - Concurrent region reads invalid while programming
// R8 - Software avoids concurrent region until re-enabled
// R9 - Software disables or relocates interrupts
// R10 - Boot section always inside stalling region
// R11 - Busy flag reads one while blocked
// R12 - Software clears busy flag before region use
// R13 - Programming is page based, reads unaffected
// R14 - Application lock bits protect application section
// R15 - Boot lock bits protect boot section
// R16 - Core halted whole stalling page operation
// R17 - Lock bits set freely, cleared by chip erase
// R18 - Lock pattern one-zero blocks writes, allows loads
// R19 - Busy flag set at start, software clears
package fsprw_pkg;
   localparam int unsigned ADDR_W         = 15;
   localparam int unsigned PAGE_OFS_W     = 7;
   localparam int unsigned PAGE_W         = ADDR_W - PAGE_OFS_W;
   // Fixed start of the stalling region (upper eighth of flash).
   localparam logic [ADDR_W-1:0] STALL_REGION_START = 15'h7000;
   // Boot section starts for boot size fuse codes 0..3 (largest to smallest).
   localparam logic [ADDR_W-1:0] BOOT_START_0 = 15'h7000;
   localparam logic [ADDR_W-1:0] BOOT_START_1 = 15'h7800;
   localparam logic [ADDR_W-1:0] BOOT_START_2 = 15'h7c00;
   localparam logic [ADDR_W-1:0] BOOT_START_3 = 15'h7e00;
   localparam logic [1:0] LOCK_RESET     = 2'h3;
   localparam int unsigned LOCK_WR_BIT   = 0;
   localparam int unsigned LOCK_RD_BIT   = 1;
   // Programming times, in microseconds, and derived cycle counts at 10 MHz.
   localparam int unsigned CLK_MHZ       = 10;
   localparam int unsigned PAGE_ERASE_US = 4000;
   localparam int unsigned PAGE_WRITE_US = 4000;
   localparam int unsigned PAGE_ERASE_CYC = PAGE_ERASE_US * CLK_MHZ;
   localparam int unsigned PAGE_WRITE_CYC = PAGE_WRITE_US * CLK_MHZ;
   localparam int unsigned TIMER_W        = 16;
   typedef enum logic [1:0] {
      FSPRW_OP_NONE,
      FSPRW_OP_ERASE,
      FSPRW_OP_WRITE
   } fsprw_op_t;
endpackage : fsprw_pkg

// ### fsprw_lock_cell.sv
// Purpose: One set of two section lock bits, settable, cleared only by chip erase or reset.
// Assumes: A zero bit means programmed; writes can only program bits.
// Notes:   Instantiated once per section.
`timescale 1ns/100ps
`default_nettype none
module fsprw_lock_cell (
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_b_i,
   // Lock control
   input  wire logic       set_i,
   input  wire logic [1:0] set_val_i,
   input  wire logic       chip_erase_i,
   // Lock state and decoded protection
   output logic      [1:0] lock_o,
   output logic            wr_block_o,
   output logic            rd_block_o
);
   import fsprw_pkg::*;
   logic [1:0] lock_q;
   logic [1:0] lock_d;
   always_comb begin
      lock_d = lock_q;
      if (chip_erase_i) begin
         lock_d = LOCK_RESET;                                   // [R17]
      end else if (set_i) begin
         // Setting can only program bits; ones written keep the old value.
         lock_d = lock_q & set_val_i;                           // [R17]
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         lock_q <= LOCK_RESET;
      end else begin
         lock_q <= lock_d;
      end
   end
   assign lock_o     = lock_q;
   assign wr_block_o = ~lock_q[LOCK_WR_BIT];                    // [R18]
   assign rd_block_o = ~lock_q[LOCK_RD_BIT];                    // [R18]
endmodule : fsprw_lock_cell
`default_nettype wire

// ### fsprw_ctrl_chk.sv
// Purpose: Port assertions for the flash self-programming control.
// Assumes: Page operation lengths match ERASE_CYC and WRITE_CYC.
// Notes:   Bound to every fsprw_ctrl instance below.
`timescale 1ns/100ps
`default_nettype none
module fsprw_ctrl_chk import fsprw_pkg::*; #(
   parameter int unsigned ERASE_CYC = 8,
   parameter int unsigned WRITE_CYC = 8
) (
   // Clock, reset and core requests
   input wire logic              sys_clk_i, rst_b_i, store_program_memory_instr_i,
   input wire logic              fetch_req_i, program_memory_load_i, chip_erase_i,
   input wire logic [ADDR_W-1:0] pc_addr_i, spm_addr_i, read_addr_i,
   // Block outputs
   input wire logic              flash_erase_o, flash_write_o, cpu_stall_o, read_valid_o,
   input wire logic              spm_accepted_o, spm_rejected_o, concurrent_region_busy_flag_o,
   input wire logic [PAGE_W-1:0] flash_page_o,
   input wire logic [1:0]        application_lock_bits_o, boot_section_lock_bits_o
);
   localparam logic [PAGE_W-1:0] SP = STALL_REGION_START[ADDR_W-1:PAGE_OFS_W];
   logic              op, store_program_memory_instr;
   logic [PAGE_W-1:0] rp;
   logic [3:0]        lk;
   int                cnt_q, cnt_d;
   assign op = flash_erase_o | flash_write_o;
   assign store_program_memory_instr = store_program_memory_instr_i;
   assign rp = spm_addr_i[ADDR_W-1:PAGE_OFS_W];
   assign lk = {application_lock_bits_o, boot_section_lock_bits_o};
   // A counter judges the operation length, since repetition counts cannot take parameters.
   always_comb cnt_d = op ? cnt_q + 1 : 0;
   always_ff @(posedge sys_clk_i) cnt_q <= rst_b_i ? cnt_d : 0;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   app_pc_a: assert property (store_program_memory_instr && pc_addr_i < STALL_REGION_START |=> spm_rejected_o)
      else $error("store from application code not refused");
   accept_page_a: assert property (spm_accepted_o |-> op && flash_page_o == $past(rp))
      else $error("accepted operation on wrong page");
   stall_page_a: assert property (cpu_stall_o |-> op && flash_page_o >= SP)
      else $error("stall outside a stalling page operation");
   conc_op_a: assert property (
      op && flash_page_o < SP |-> concurrent_region_busy_flag_o && !cpu_stall_o)
      else $error("concurrent page operation flagged wrongly");
   read_block_a: assert property (
      (fetch_req_i | program_memory_load_i) && read_addr_i < STALL_REGION_START
      && concurrent_region_busy_flag_o |-> !read_valid_o) else $error("busy region read");
   write_len_a: assert property ($fell(flash_write_o) |-> cnt_q == WRITE_CYC)
      else $error("page write length wrong");
   erase_len_a: assert property ($fell(flash_erase_o) |-> cnt_q == ERASE_CYC)
      else $error("page erase length wrong");
   app_lock_a: assert property (
      store_program_memory_instr && !application_lock_bits_o[0] && spm_addr_i < STALL_REGION_START |=> spm_rejected_o)
      else $error("application lock ignored");
   boot_lock_a: assert property (
      store_program_memory_instr && !boot_section_lock_bits_o[0] && spm_addr_i >= BOOT_START_3 |=> spm_rejected_o)
      else $error("boot lock ignored");
   lock_clear_a: assert property (
      |(lk & ~$past(lk)) |-> $past(chip_erase_i) || !$past(rst_b_i))
      else $error("lock bit cleared without chip erase");
   cover property (cpu_stall_o);
   cover property (spm_accepted_o && concurrent_region_busy_flag_o);
   busy_reject_a: assert property (store_program_memory_instr && op |=> spm_rejected_o && !spm_accepted_o)
      else $error("store during page operation not refused");
   cover property (spm_rejected_o);
   cover property (spm_rejected_o && op);
endmodule : fsprw_ctrl_chk
bind fsprw_ctrl fsprw_ctrl_chk #(.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC))
   i_fsprw_ctrl_chk (.*);
`default_nettype wire

// ### fsprw_core_model.sv
// Purpose: Core model issuing fetches and loads to the flash control.
// Assumes: The bench names the address and whether the busy flag is obeyed.
// Notes:   Idle address lines invert so a stale address never passes.
`timescale 1ns/100ps
`default_nettype none
module fsprw_core_model (
   input  wire logic        sys_clk_i, rd_i, ld_i, obey_i, busy_i, stall_i,
   input  wire logic [14:0] addr_i,
   output logic             fetch_req_o, load_o,
   output logic [14:0]      read_addr_o
);
   import fsprw_pkg::*;
   logic hold;
   // A halted core issues nothing; an obedient one avoids the busy region.
   assign hold = stall_i | (obey_i & busy_i & (addr_i < STALL_REGION_START));
   initial {fetch_req_o, load_o, read_addr_o} = '0;
   always @(negedge sys_clk_i) begin
      fetch_req_o <= rd_i & ~hold;
      load_o      <= ld_i & ~hold;
      read_addr_o <= (rd_i | ld_i) ? addr_i : ~read_addr_o;
   end
endmodule : fsprw_core_model
`default_nettype wire

// ### tb_fsprw_ctrl.sv
// Purpose: Self-checking bench for the flash self-programming control.
// Assumes: Page operations shortened to 8 cycles.
// Notes:   Inputs move on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module tb_fsprw_ctrl;
   import fsprw_pkg::*;
   localparam int OPC = 8;
   logic clk = 0, rst_b = 0, store_program_memory_instr = 0, ls = 0, ce = 0, clr = 0, rd = 0, ld = 0, ob = 1;
   logic fr, pl, er, wr, stl, rv, acc, rej, busy;
   logic [1:0] fuse = 2'h0, aset = 2'h3, bset = 2'h3, alk, blk;
   logic [ADDR_W-1:0] pc = '0, sa = '0, ra = '0, raddr;
   logic [PAGE_W-1:0] pg;
   fsprw_op_t op = FSPRW_OP_NONE;
   int failures = 0, comparisons = 0, act, st;
   fsprw_ctrl #(.ERASE_CYC(OPC), .WRITE_CYC(OPC)) i_fsprw_ctrl (.sys_clk_i(clk), .rst_b_i(rst_b),
      .boot_size_fuses_i(fuse), .store_program_memory_instr_i(store_program_memory_instr), .spm_op_i(op),
      .pc_addr_i(pc), .spm_addr_i(sa), .fetch_req_i(fr), .program_memory_load_i(pl),
      .read_addr_i(raddr), .lock_set_i(ls), .application_lock_bits_set_i(aset),
      .boot_section_lock_bits_set_i(bset), .chip_erase_i(ce), .busy_flag_clear_i(clr),
      .flash_erase_o(er), .flash_write_o(wr), .flash_page_o(pg), .cpu_stall_o(stl),
      .read_valid_o(rv), .spm_accepted_o(acc), .spm_rejected_o(rej),
      .concurrent_region_busy_flag_o(busy), .application_lock_bits_o(alk),
      .boot_section_lock_bits_o(blk));
   fsprw_core_model i_fsprw_core_model (.sys_clk_i(clk), .rd_i(rd), .ld_i(ld), .obey_i(ob),
      .busy_i(busy), .stall_i(stl), .addr_i(ra), .fetch_req_o(fr), .load_o(pl),
      .read_addr_o(raddr));
   initial forever #50 clk = ~clk;
   task automatic chk(input logic c, input string m);
      comparisons++;
      if (c !== 1'b1) begin
         failures++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic req(input fsprw_op_t o, input logic [14:0] p, a, input logic ok);
      @(negedge clk);
      store_program_memory_instr <= 1'b1;
      op  <= o;
      pc  <= p;
      sa  <= a;
      @(negedge clk);
      store_program_memory_instr <= 1'b0;
      chk(acc === ok && rej === !ok, "store answer");
   endtask : req
   task automatic rdchk(input logic [14:0] a, input logic l, o, ok);
      @(negedge clk);
      {ra, rd, ld, ob} <= {a, !l, l, o};
      @(negedge clk);
      #1 chk(rv === ok, "read valid");
   endtask : rdchk
   task automatic done();
      {act, st} = '0;
      for (int i = 0; i < 50 && (er | wr) === 1'b1; i++) begin
         act += 1;
         st += int'(stl === 1'b1);
         @(negedge clk);
      end
   endtask : done
   task automatic pulse(input int k);
      @(negedge clk);
      {ls, ce, clr} <= 3'(k);
      @(negedge clk);
      {ls, ce, clr} <= 3'h0;
   endtask : pulse
   task automatic t_app();
      req(FSPRW_OP_WRITE, 15'h0100, 15'h0200, 1'b0);
      req(FSPRW_OP_NONE, 15'h7f00, 15'h0200, 1'b0);
      $display("app test done");
   endtask : t_app
   task automatic t_rww();
      req(FSPRW_OP_WRITE, 15'h7f00, 15'h0100, 1'b1);
      chk(wr === 1'b1 && stl === 1'b0 && busy === 1'b1 && pg === 8'h02, "start");
      req(FSPRW_OP_ERASE, 15'h7f00, 15'h0180, 1'b0);
      chk(wr === 1'b1 && pg === 8'h02, "busy request ignored");
      rdchk(15'h7100, 1'b0, 1'b0, 1'b1);
      rdchk(15'h0100, 1'b0, 1'b0, 1'b0);
      done();
      chk(busy === 1'b1, "busy held");
      pulse(1);
      chk(busy === 1'b0, "busy clear");
      rdchk(15'h0100, 1'b0, 1'b1, 1'b1);
      $display("rww test done");
   endtask : t_rww
   task automatic t_stalling_region();
      @(negedge clk);
      fuse <= 2'h3;
      req(FSPRW_OP_ERASE, 15'h7e00, 15'h7e80, 1'b1);
      done();
      chk(act == OPC && st == OPC && busy === 1'b0, "stall span");
      $display("stalling_region test done");
   endtask : t_stalling_region
   task automatic t_lock();
      {aset, bset} <= 4'ha;
      pulse(4);
      {aset, bset} <= 4'hf;
      chk(alk === 2'h2 && blk === 2'h2, "locks set");
      req(FSPRW_OP_WRITE, 15'h7f00, 15'h0100, 1'b0);
      req(FSPRW_OP_WRITE, 15'h7f00, 15'h7f80, 1'b0);
      rdchk(15'h0100, 1'b1, 1'b1, 1'b1);
      pulse(4);
      chk(alk === 2'h2, "set cannot clear");
      pulse(2);
      chk(alk === 2'h3 && blk === 2'h3, "chip erase");
      $display("lock test done");
   endtask : t_lock
   task automatic t_fuse();
      logic [14:0] bs [4] = '{BOOT_START_0, BOOT_START_1, BOOT_START_2, BOOT_START_3};
      for (int f = 0; f < 4; f++) begin
         fuse <= 2'(f);
         req(FSPRW_OP_ERASE, bs[f] - 15'h1, 15'h7f80, 1'b0);
         req(FSPRW_OP_ERASE, bs[f], 15'h7f80, 1'b1);
         done();
      end
      $display("fuse test done");
   endtask : t_fuse
   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   initial begin
      #200000;
      failures++;
      finish_test();
   end
   initial begin
      repeat (16) @(negedge clk);
      rst_b <= 1'b1;
      t_app();
      t_rww();
      t_stalling_region();
      t_lock();
      t_fuse();
      finish_test();
   end
endmodule : tb_fsprw_ctrl
`default_nettype wire
